// ===== src/ahss_pkg.sv
// Purpose: Shared constants for the axis home-search sequencer.
// Assumes: Positions and distances are signed counts of 1 um.
// Notes:   Marker type value 3 selects release-then-marker homing.
package ahss_pkg;

  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int unsigned COORD_W      = 32;
  localparam int unsigned MTYPE_W      = 2;
  localparam logic [1:0]  MARK_RELEASE = 2'h3;
  localparam logic        DIFF_COMP_ON = 1'h1;

  // ----------------------------------------------------------------
  // Coded-mark travel bounds, in um
  // ----------------------------------------------------------------
  localparam int unsigned CODED_SHORT_UM = 20000;
  localparam int unsigned CODED_LONG_UM  = 100000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_FLAG = 1'h0;

endpackage

// ===== src/ahss_sequencer.sv
// Purpose: Home-search sequencer for a set of axes with one gantry pair.
// Assumes: Servo loop applies MOVE/DIR/feed select; it runs shift and
//          slave-correction moves on request and acknowledges them.
// Notes:   Axes are homed in ascending index order.
// Functional notes
// - Jog start cancels zero offset, loads reference
// - Switched non-coded axes approach at first feedrate
// - Then marker search per axis, second feedrate
// - Type 3: back off, take first marker
// - Coded axes: one by one, bounded travel
// - Coded search reverses when switch pressed
// - After marker, run shift at second feedrate
// - Coded axes load position minus encoder offset
// - Gantry approach together until master switch
// - Gantry markers: slave first, then master
// - Coded gantry: correct slave on offset mismatch
// - Gantry type 3: release, then slave, master
// - Gantry jog start cancels zero offset too
// - Two switches: type 3, stop on either
// - Home first switcher, approach second, home it
// - Compensate difference per compensation setting
// - Master homed first: shift finishes before second search
// - Pressed switch homes first; both: master first
// - Mixed homing: all switches first, then order
// - Compensation on drives difference to zero
// - Compensation on or coded: excess difference raises flag
// - No switch: search first marker only
`timescale 1ns/1ps

module ahss_sequencer #(
  parameter int N_AXES = 4,
  parameter int MASTER = 0,
  parameter int SLAVE  = 1,
  parameter int W      = ahss_pkg::COORD_W
) (
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RESET_I,
  input  wire logic                  CLK_EN_I,
  input  wire logic                  START_I,
  input  wire logic                  JOG_MODE_I,
  input  wire logic [N_AXES-1:0]     SELECT_I,
  input  wire logic [N_AXES-1:0]     HAS_HOME_SWITCH_I,
  input  wire logic [N_AXES-1:0]     HOMING_DIRECTION_I,
  input  wire logic [N_AXES-1:0]     CODED_I,
  input  wire logic [N_AXES-1:0]     CODED_LONG_I,
  input  wire logic [2*N_AXES-1:0]   MARKER_TYPE_SELECT_I,
  input  wire logic [N_AXES-1:0]     HOME_SWITCH_SIGNAL_I,
  input  wire logic [N_AXES-1:0]     MARKER_I,
  input  wire logic [N_AXES*W-1:0]   POS_I,
  input  wire logic [N_AXES*W-1:0]   REFERENCE_POINT_COORDINATE_I,
  input  wire logic [N_AXES*W-1:0]   MARKER_SHIFT_DISTANCE_I,
  input  wire logic [N_AXES*W-1:0]   CODED_ENCODER_OFFSET_I,
  input  wire logic                  GANTRY_EN_I,
  input  wire logic                  GANTRY_DIFF_COMPENSATE_I,
  input  wire logic [W-1:0]          GANTRY_MAX_DIFFERENCE_I,
  input  wire logic                  SHIFT_DONE_I,
  input  wire logic                  CORR_DONE_I,
  output logic      [N_AXES-1:0]     MOVE_O,
  output logic      [N_AXES-1:0]     DIR_O,
  output logic      [N_AXES-1:0]     APPROACH_FEEDRATE_O,
  output logic      [N_AXES-1:0]     SHIFT_REQ_O,
  output logic      [W-1:0]          SHIFT_DIST_O,
  output logic                       COORD_LOAD_O,
  output logic      [$clog2(N_AXES)-1:0] COORD_AXIS_O,
  output logic      [W-1:0]          COORD_VALUE_O,
  output logic                       ZERO_CANCEL_O,
  output logic                       SLAVE_CORR_O,
  output logic      [W-1:0]          SLAVE_CORR_VALUE_O,
  output logic                       EXCESS_DIFF_O,
  output logic                       TRAVEL_FAULT_O,
  output logic      [N_AXES-1:0]     HOMED_O,
  output logic                       BUSY_O
);

  localparam int            AW    = $clog2(N_AXES);
  localparam logic [AW-1:0] M_IDX = AW'(MASTER);
  localparam logic [AW-1:0] S_IDX = AW'(SLAVE);

  typedef enum logic [3:0] {
    S_IDLE, S_APPR, S_PICK, S_REL, S_MARK, S_SHIFT, S_APPR2, S_DIFF, S_CORR
  } ahss_state_t;

  ahss_state_t       state;
  logic [AW-1:0]     cur;
  logic [AW-1:0]     mk_ax;
  logic [N_AXES-1:0] sel;
  logic [N_AXES-1:0] reached;
  logic [N_AXES-1:0] mdir;
  logic [N_AXES-1:0] sw_q;
  logic              gstep;
  logic              fst_s;
  logic              jog;
  logic [W-1:0]      start_pos;
  logic [W-1:0]      off_m;
  logic [W-1:0]      off_s;

  logic [N_AXES-1:0] is_t3;
  logic [N_AXES-1:0] appr_need;
  logic              two_sw;
  logic              gcur;
  logic              pick_ok;
  logic [AW-1:0]     pick_ax;
  logic              mk_hit;
  logic              shift_on;
  logic [W-1:0]      ld_val;
  logic [W-1:0]      travel;
  logic              trv_over;
  logic [W-1:0]      diff_err;
  logic              diff_big;
  logic [N_AXES-1:0] next_move;
  logic [N_AXES-1:0] next_dir;
  logic [N_AXES-1:0] next_fast;

  function automatic logic [W-1:0] mag(input logic [W-1:0] v);
    mag = v[W-1] ? (~v + 1'b1) : v;
  endfunction

  function automatic logic [W-1:0] word(input logic [N_AXES*W-1:0] v, input logic [AW-1:0] a);
    word = v[a*W +: W];
  endfunction

  // ----------------------------------------------------------------
  // Per-axis qualifiers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_AXES; g++) begin : g_axis
      assign is_t3[g]     = MARKER_TYPE_SELECT_I[2*g +: 2] == ahss_pkg::MARK_RELEASE;
      // Gantry slave rides on the master, never approaches alone
      assign appr_need[g] = sel[g] & HAS_HOME_SWITCH_I[g] & ~CODED_I[g] & ~reached[g]
                            & ~(GANTRY_EN_I & (g == SLAVE));
    end
  endgenerate

  assign two_sw = GANTRY_EN_I & is_t3[MASTER] & HAS_HOME_SWITCH_I[MASTER]
                  & HAS_HOME_SWITCH_I[SLAVE];
  assign gcur   = GANTRY_EN_I & (cur == M_IDX);

  // ----------------------------------------------------------------
  // Event terms
  // ----------------------------------------------------------------
  always_comb begin
    pick_ok = 1'b0;
    pick_ax = '0;
    for (int i = N_AXES - 1; i >= 0; i--) begin
      if (sel[i] && !(GANTRY_EN_I && i == SLAVE) && !HOMED_O[i]) begin
        pick_ok = 1'b1;
        pick_ax = AW'(i);
      end
    end
  end

  assign mk_hit   = (state == S_MARK) & MARKER_I[mk_ax];
  assign shift_on = ~(GANTRY_EN_I & (mk_ax == S_IDX)) & (word(MARKER_SHIFT_DISTANCE_I, mk_ax) != '0);
  // Loaded so that the point reached after the shift move carries the reference
  assign ld_val   = (CODED_I[mk_ax] ? word(POS_I, mk_ax) - word(CODED_ENCODER_OFFSET_I, mk_ax)
                                    : word(REFERENCE_POINT_COORDINATE_I, mk_ax))
                    - (shift_on ? word(MARKER_SHIFT_DISTANCE_I, mk_ax) : '0);
  assign travel   = mag(word(POS_I, cur) - start_pos);
  assign trv_over = CODED_I[cur] & (travel >= (CODED_LONG_I[cur] ? W'(ahss_pkg::CODED_LONG_UM)
                                                               : W'(ahss_pkg::CODED_SHORT_UM)));
  assign diff_err = (word(POS_I, M_IDX) + off_m) - (word(POS_I, S_IDX) + off_s)
                    - (word(REFERENCE_POINT_COORDINATE_I, M_IDX) - word(REFERENCE_POINT_COORDINATE_I, S_IDX));
  assign diff_big = mag(diff_err) > GANTRY_MAX_DIFFERENCE_I;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state     <= S_IDLE;
      cur       <= '0;
      mk_ax     <= '0;
      sel       <= '0;
      reached   <= '0;
      mdir      <= '0;
      sw_q      <= '0;
      gstep     <= ahss_pkg::RST_FLAG;
      fst_s     <= ahss_pkg::RST_FLAG;
      jog       <= ahss_pkg::RST_FLAG;
      start_pos <= '0;
      off_m     <= '0;
      off_s     <= '0;
      HOMED_O   <= '0;
    end else if (CLK_EN_I) begin
      sw_q <= HOME_SWITCH_SIGNAL_I;
      case (state)
        S_IDLE: if (START_I) begin
          sel     <= SELECT_I;
          reached <= '0;
          HOMED_O <= '0;
          mdir    <= HOMING_DIRECTION_I;
          jog     <= JOG_MODE_I;
          state   <= S_APPR;
        end
        S_APPR: begin
          // An already pressed switch counts as reached at once
          reached <= reached | HOME_SWITCH_SIGNAL_I;
          if (GANTRY_EN_I && !reached[MASTER] && (HOME_SWITCH_SIGNAL_I[MASTER]
              || (two_sw && HOME_SWITCH_SIGNAL_I[SLAVE]))) begin
            reached[MASTER] <= 1'b1;
            fst_s <= two_sw & HOME_SWITCH_SIGNAL_I[SLAVE] & ~HOME_SWITCH_SIGNAL_I[MASTER];
          end
          if (appr_need == '0) begin
            state <= S_PICK;
          end
        end
        S_PICK: begin
          if (!pick_ok) begin
            state <= S_IDLE;
          end else begin
            cur       <= pick_ax;
            gstep     <= 1'b0;
            start_pos <= word(POS_I, pick_ax);
            if (GANTRY_EN_I && pick_ax == M_IDX) begin
              mk_ax <= two_sw ? (fst_s ? S_IDX : M_IDX) : S_IDX;
            end else begin
              mk_ax <= pick_ax;
            end
            if (!CODED_I[pick_ax] && HAS_HOME_SWITCH_I[pick_ax] && is_t3[pick_ax]) begin
              mdir[pick_ax] <= ~HOMING_DIRECTION_I[pick_ax];
              state         <= S_REL;
            end else begin
              state <= S_MARK;
            end
          end
        end
        S_REL: if (!HOME_SWITCH_SIGNAL_I[mk_ax]) begin
          state <= S_MARK;
        end
        S_MARK: begin
          if (CODED_I[cur] && HAS_HOME_SWITCH_I[cur] && HOME_SWITCH_SIGNAL_I[cur] && !sw_q[cur]) begin
            mdir[cur] <= ~mdir[cur];
          end
          if (mk_hit) begin
            if (mk_ax == M_IDX) begin
              off_m <= ld_val - word(POS_I, mk_ax);
            end
            if (mk_ax == S_IDX) begin
              off_s <= ld_val - word(POS_I, mk_ax);
            end
            if (gcur && !two_sw && !gstep) begin
              mk_ax <= M_IDX;
              gstep <= 1'b1;
            end else if (shift_on) begin
              state <= S_SHIFT;
            end else if (gcur && two_sw && !gstep) begin
              state <= S_APPR2;
            end else if (gcur) begin
              state <= S_DIFF;
            end else begin
              HOMED_O[cur] <= 1'b1;
              state        <= S_PICK;
            end
          end else if (trv_over) begin
            sel[cur] <= 1'b0;
            if (gcur) begin
              sel[SLAVE] <= 1'b0;
            end
            state <= S_PICK;
          end
        end
        S_SHIFT: if (SHIFT_DONE_I) begin
          if (gcur && two_sw && !gstep) begin
            state <= S_APPR2;
          end else if (gcur) begin
            state <= S_DIFF;
          end else begin
            HOMED_O[cur] <= 1'b1;
            state        <= S_PICK;
          end
        end
        S_APPR2: begin
          if (!gstep) begin
            gstep        <= 1'b1;
            mk_ax        <= (mk_ax == M_IDX) ? S_IDX : M_IDX;
            mdir[MASTER] <= HOMING_DIRECTION_I[MASTER];
          end else if (HOME_SWITCH_SIGNAL_I[mk_ax]) begin
            mdir[MASTER] <= ~HOMING_DIRECTION_I[MASTER];
            state        <= S_REL;
          end
        end
        S_DIFF: begin
          if ((GANTRY_DIFF_COMPENSATE_I == ahss_pkg::DIFF_COMP_ON || CODED_I[MASTER])
              && !diff_big && diff_err != '0) begin
            state <= S_CORR;
          end else begin
            HOMED_O[MASTER] <= 1'b1;
            HOMED_O[SLAVE]  <= 1'b1;
            state           <= S_PICK;
          end
        end
        S_CORR: if (CORR_DONE_I) begin
          HOMED_O[MASTER] <= 1'b1;
          HOMED_O[SLAVE]  <= 1'b1;
          state           <= S_PICK;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Motion commands
  // ----------------------------------------------------------------
  always_comb begin
    next_move = '0;
    next_fast = '0;
    next_dir  = mdir;
    case (state)
      S_APPR: begin
        next_move = appr_need;
        next_fast = appr_need;
      end
      S_REL, S_MARK: next_move[cur] = ~mk_hit & ~trv_over;
      S_APPR2: begin
        next_move[cur] = 1'b1;
        next_fast[cur] = 1'b1;
      end
      default: ;
    endcase
    // Slave mirrors master direction and feed select
    if (GANTRY_EN_I) begin
      next_move[SLAVE] = next_move[MASTER];
      next_fast[SLAVE] = next_fast[MASTER];
      next_dir[SLAVE]  = mdir[MASTER];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      MOVE_O              <= '0;
      DIR_O               <= '0;
      APPROACH_FEEDRATE_O <= '0;
      BUSY_O              <= ahss_pkg::RST_FLAG;
    end else if (CLK_EN_I) begin
      MOVE_O              <= next_move;
      DIR_O               <= next_dir;
      APPROACH_FEEDRATE_O <= next_fast;
      BUSY_O              <= state != S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Coordinate, shift and gantry reports
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      COORD_LOAD_O       <= ahss_pkg::RST_FLAG;
      COORD_AXIS_O       <= '0;
      COORD_VALUE_O      <= '0;
      ZERO_CANCEL_O      <= ahss_pkg::RST_FLAG;
      SHIFT_REQ_O        <= '0;
      SHIFT_DIST_O       <= '0;
      SLAVE_CORR_O       <= ahss_pkg::RST_FLAG;
      SLAVE_CORR_VALUE_O <= '0;
      EXCESS_DIFF_O      <= ahss_pkg::RST_FLAG;
      TRAVEL_FAULT_O     <= ahss_pkg::RST_FLAG;
    end else if (CLK_EN_I) begin
      COORD_LOAD_O  <= mk_hit;
      ZERO_CANCEL_O <= mk_hit & jog;
      SHIFT_REQ_O   <= '0;
      SLAVE_CORR_O  <= 1'b0;
      if (mk_hit) begin
        COORD_AXIS_O  <= mk_ax;
        COORD_VALUE_O <= ld_val;
        if (shift_on) begin
          SHIFT_REQ_O[mk_ax] <= 1'b1;
          SHIFT_DIST_O       <= word(MARKER_SHIFT_DISTANCE_I, mk_ax);
        end
      end
      if (state == S_IDLE && START_I) begin
        EXCESS_DIFF_O  <= 1'b0;
        TRAVEL_FAULT_O <= 1'b0;
      end
      if (state == S_DIFF) begin
        if (GANTRY_DIFF_COMPENSATE_I == ahss_pkg::DIFF_COMP_ON || CODED_I[MASTER]) begin
          EXCESS_DIFF_O      <= diff_big;
          SLAVE_CORR_O       <= ~diff_big & (diff_err != '0);
          SLAVE_CORR_VALUE_O <= diff_err;
        end
      end
      if (state == S_MARK && !mk_hit && trv_over) begin
        TRAVEL_FAULT_O <= 1'b1;
      end
    end
  end

endmodule // ahss_sequencer

// ===== verification/ahss_sequencer_sva.sv
// Purpose: Port checker for the axis home-search sequencer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound into every ahss_sequencer instance.
`timescale 1ns/1ps

module ahss_checker #(
  parameter int N_AXES = 4,
  parameter int MASTER = 0,
  parameter int SLAVE  = 1,
  parameter int W      = 32
) (
  input wire logic                      SYS_CLK_I,
  input wire logic                      RESET_I,
  input wire logic                      CLK_EN_I,
  input wire logic                      START_I,
  input wire logic                      JOG_MODE_I,
  input wire logic [N_AXES-1:0]         HOMING_DIRECTION_I,
  input wire logic [N_AXES-1:0]         CODED_I,
  input wire logic [N_AXES-1:0]         HOME_SWITCH_SIGNAL_I,
  input wire logic [N_AXES-1:0]         MARKER_I,
  input wire logic [N_AXES*W-1:0]       REFERENCE_POINT_COORDINATE_I,
  input wire logic [N_AXES*W-1:0]       MARKER_SHIFT_DISTANCE_I,
  input wire logic                      GANTRY_EN_I,
  input wire logic [N_AXES-1:0]         MOVE_O,
  input wire logic [N_AXES-1:0]         DIR_O,
  input wire logic [N_AXES-1:0]         APPROACH_FEEDRATE_O,
  input wire logic [N_AXES-1:0]         SHIFT_REQ_O,
  input wire logic [W-1:0]              SHIFT_DIST_O,
  input wire logic                      COORD_LOAD_O,
  input wire logic [$clog2(N_AXES)-1:0] COORD_AXIS_O,
  input wire logic [W-1:0]              COORD_VALUE_O,
  input wire logic                      ZERO_CANCEL_O,
  input wire logic [N_AXES-1:0]         HOMED_O,
  input wire logic                      BUSY_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  // Jog flag as taken with the accepted start
  logic jog_q;
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) jog_q <= 1'h0;
    else if (CLK_EN_I && START_I && !BUSY_O) jog_q <= JOG_MODE_I;
  end

  sequence s_start;
    CLK_EN_I && START_I && !BUSY_O;
  endsequence
  property p_start;
    s_start |-> ##2 BUSY_O;
  endproperty
  a_start: assert property (p_start) else $error("busy did not follow start");

  property p_load_zc;
    (COORD_LOAD_O || ZERO_CANCEL_O) |-> (COORD_LOAD_O && ZERO_CANCEL_O == jog_q);
  endproperty
  a_load_zc: assert property (p_load_zc) else $error("zero cancel wrong");

  property p_load_val;
    COORD_LOAD_O && !GANTRY_EN_I && !CODED_I[COORD_AXIS_O] |-> COORD_VALUE_O ==
      REFERENCE_POINT_COORDINATE_I[COORD_AXIS_O*W +: W] - MARKER_SHIFT_DISTANCE_I[COORD_AXIS_O*W +: W];
  endproperty
  a_load_val: assert property (p_load_val) else $error("loaded coordinate wrong");

  property p_gantry;
    GANTRY_EN_I && MOVE_O[MASTER] && APPROACH_FEEDRATE_O[MASTER] |-> MOVE_O[SLAVE] &&
      APPROACH_FEEDRATE_O[SLAVE] && DIR_O[SLAVE] == HOMING_DIRECTION_I[MASTER];
  endproperty
  a_gantry: assert property (p_gantry) else $error("gantry pair not moving together");

  for (genvar i = 0; i < N_AXES; i++) begin : g_ax
    sequence s_hit;
      MOVE_O[i] && !APPROACH_FEEDRATE_O[i] && MARKER_I[i] && !HOME_SWITCH_SIGNAL_I[i] &&
        !$past(HOME_SWITCH_SIGNAL_I[i]) && !GANTRY_EN_I;
    endsequence
    sequence s_load;
      COORD_LOAD_O && COORD_AXIS_O == i;
    endsequence
    property p_marker;
      s_hit |=> s_load;
    endproperty
    a_marker: assert property (p_marker) else $error("marker not taken");
    property p_appr_dir;
      MOVE_O[i] && APPROACH_FEEDRATE_O[i] && !GANTRY_EN_I |-> DIR_O[i] == HOMING_DIRECTION_I[i];
    endproperty
    a_appr_dir: assert property (p_appr_dir) else $error("approach direction wrong");
    property p_coded;
      MOVE_O[i] && CODED_I[i] |-> !APPROACH_FEEDRATE_O[i];
    endproperty
    a_coded: assert property (p_coded) else $error("coded axis at approach feed");
    property p_shift;
      SHIFT_REQ_O[i] |-> SHIFT_DIST_O == MARKER_SHIFT_DISTANCE_I[i*W +: W] ##1 SHIFT_REQ_O == '0;
    endproperty
    a_shift: assert property (p_shift) else $error("shift request wrong");
    property p_homed;
      $rose(HOMED_O[i]) |-> !MOVE_O[i] && !SHIFT_REQ_O[i];
    endproperty
    a_homed: assert property (p_homed) else $error("homed while moving");
  end
endmodule // ahss_checker

bind ahss_sequencer ahss_checker #(.N_AXES(N_AXES), .MASTER(MASTER), .SLAVE(SLAVE), .W(W)) ahss_checker_inst (
  .SYS_CLK_I, .RESET_I, .CLK_EN_I, .START_I, .JOG_MODE_I, .HOMING_DIRECTION_I, .CODED_I,
  .HOME_SWITCH_SIGNAL_I, .MARKER_I, .REFERENCE_POINT_COORDINATE_I, .MARKER_SHIFT_DISTANCE_I,
  .GANTRY_EN_I, .MOVE_O, .DIR_O, .APPROACH_FEEDRATE_O, .SHIFT_REQ_O, .SHIFT_DIST_O, .COORD_LOAD_O,
  .COORD_AXIS_O, .COORD_VALUE_O, .ZERO_CANCEL_O, .HOMED_O, .BUSY_O);

// ===== verification/ahss_partner.sv
// Purpose: Drives, encoders and switches behind the sequencer.
// Assumes: 1 um per cycle at search feed, 4 um at approach feed.
// Notes:   Markers every 37 um, away from the switch edge at 200 um.
`timescale 1ns/1ps

module ahss_partner #(
  parameter int N = 4,
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] move_i,
  input  wire logic [N-1:0] dir_i,
  input  wire logic [N-1:0] feed_i,
  input  wire logic [N-1:0] has_sw_i,
  input  wire logic [N-1:0] hdir_i,
  input  wire logic [N-1:0] shift_req_i,
  input  wire logic         corr_i,
  output logic [N-1:0]      sw_o,
  output logic [N-1:0]      marker_o,
  output logic [N*W-1:0]    pos_o,
  output logic              shift_done_o,
  output logic              corr_done_o
);
  int p [N];
  int sc;
  int cc;
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < N; i++) begin
      if (rst_i) p[i] <= 0;
      else if (move_i[i]) p[i] <= p[i] + (dir_i[i] ? 1 : -1) * (feed_i[i] ? 4 : 1);
    end
  end
  // Shift and correction moves take a few cycles, never zero
  always_ff @(posedge clk_i) begin
    sc <= rst_i ? 0 : (|shift_req_i) ? 6 : (sc > 0) ? sc - 1 : 0;
    cc <= rst_i ? 0 : corr_i ? 4 : (cc > 0) ? cc - 1 : 0;
  end
  assign shift_done_o = (sc == 1);
  assign corr_done_o  = (cc == 1);
  always_comb begin
    for (int i = 0; i < N; i++) begin
      sw_o[i] = has_sw_i[i] && ((hdir_i[i] ? p[i] : -p[i]) >= 200);
      marker_o[i] = move_i[i] && (p[i] % 37 == 0);
      pos_o[i*W +: W] = p[i];
    end
  end
endmodule // ahss_partner

// ===== verification/tb_axis_home_search_sequencer.sv
// Purpose: Self-checking bench for the home-search sequencer.
// Assumes: Inputs change on the falling edge only.
// Notes:   Coordinate loads are matched in order against a queue.
`timescale 1ns/1ps

module tb_axis_home_search_sequencer;
  localparam int N = 4;
  localparam int W = 32;
  typedef struct {logic [1:0] ax; logic [W-1:0] v; logic c; logic zc;} ahss_exp_t;
  logic clk, rst, start, jog, gen, dcomp, sdone, cdone, load, zc, scorr, exc, flt, busy;
  logic [N-1:0] sel, hsw, hdir, coded, clong, sw, mk, mv, dir, feed, sreq, homed;
  logic [2*N-1:0] mtype;
  logic [N*W-1:0] refc, shd, offc, pos;
  logic [W-1:0] maxd, sdist, cval, corrv;
  logic [1:0] cax;
  ahss_exp_t q[$];
  ahss_exp_t e;
  int bad_count, num_checks, seed, cyc;

  ahss_sequencer ahss_sequencer_inst (.SYS_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'h1), .START_I(start),
    .JOG_MODE_I(jog), .SELECT_I(sel), .HAS_HOME_SWITCH_I(hsw), .HOMING_DIRECTION_I(hdir), .CODED_I(coded),
    .CODED_LONG_I(clong), .MARKER_TYPE_SELECT_I(mtype), .HOME_SWITCH_SIGNAL_I(sw), .MARKER_I(mk),
    .POS_I(pos), .REFERENCE_POINT_COORDINATE_I(refc), .MARKER_SHIFT_DISTANCE_I(shd),
    .CODED_ENCODER_OFFSET_I(offc), .GANTRY_EN_I(gen), .GANTRY_DIFF_COMPENSATE_I(dcomp),
    .GANTRY_MAX_DIFFERENCE_I(maxd), .SHIFT_DONE_I(sdone), .CORR_DONE_I(cdone), .MOVE_O(mv), .DIR_O(dir),
    .APPROACH_FEEDRATE_O(feed), .SHIFT_REQ_O(sreq), .SHIFT_DIST_O(sdist), .COORD_LOAD_O(load),
    .COORD_AXIS_O(cax), .COORD_VALUE_O(cval), .ZERO_CANCEL_O(zc), .SLAVE_CORR_O(scorr),
    .SLAVE_CORR_VALUE_O(corrv), .EXCESS_DIFF_O(exc), .TRAVEL_FAULT_O(flt), .HOMED_O(homed), .BUSY_O(busy));
  ahss_partner ahss_partner_inst (.clk_i(clk), .rst_i(rst), .move_i(mv), .dir_i(dir), .feed_i(feed),
    .has_sw_i(hsw), .hdir_i(hdir), .shift_req_i(sreq), .corr_i(scorr), .sw_o(sw), .marker_o(mk),
    .pos_o(pos), .shift_done_o(sdone), .corr_done_o(cdone));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic fail(input string m);
    bad_count++;
    $display("ERROR %0t %s", $time, m);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail("timeout");
      conclude();
    end
  end

  // Monitor: loads are one-cycle pulses, seen at exactly one falling edge
  always @(negedge clk) begin
    if (load === 1'h1) begin
      num_checks++;
      if (q.size() == 0) fail("unexpected load");
      else begin
        e = q.pop_front();
        if (cax !== e.ax || zc !== e.zc || (e.c && cval !== e.v)) fail("load mismatch");
      end
    end
  end

  task automatic note(input int i, input logic c);
    q.push_back('{2'(i), refc[i*W +: W] - (i == 1 && gen ? '0 : shd[i*W +: W]), c, jog});
  endtask

  // Second start inside the run must be ignored
  task automatic go(input logic [N-1:0] exp_homed);
    int t;
    @(negedge clk) start = 1'h1;
    @(negedge clk) start = 1'h0;
    for (t = 0; t < 20 && busy !== 1'h1; t++) @(negedge clk);
    @(negedge clk) start = 1'h1;
    @(negedge clk) start = 1'h0;
    for (t = 0; t < 40000 && busy !== 1'h0; t++) @(negedge clk);
    num_checks++;
    if (homed !== exp_homed || q.size() != 0) fail("run incomplete");
    num_checks++;
    if (exc !== 1'h0 || flt !== 1'h0) fail("fault flag raised");
  endtask

  initial begin
    seed = 42420;
    {start, jog, gen, dcomp, sel, hsw, hdir, coded, clong, mtype, refc, shd, offc, maxd} = '0;
    rst = 1'h1;
    repeat (8) @(negedge clk);
    rst = 1'h0;
    for (int k = 0; k < 8; k++) begin
      sel = N'($random(seed));
      sel[k % N] = 1'h1;
      hsw = N'($random(seed));
      hdir = N'($random(seed));
      coded = (k > 4) ? N'($random(seed)) : '0;
      clong = N'($random(seed));
      jog = k[0];
      offc = {$random(seed), $random(seed), $random(seed), $random(seed)};
      for (int i = 0; i < N; i++) begin
        mtype[2*i +: 2] = 2'((i + k) % 4);
        refc[i*W +: W] = $random(seed);
        shd[i*W +: W] = (i == k % N) ? '0 : W'($random(seed) & 32'h3FF);
        if (sel[i]) note(i, !coded[i]);
      end
      go(sel);
    end
    // Gantry pair, master switch only, slave reference below master
    gen = 1'h1;
    dcomp = 1'h1;
    sel = 4'h3;
    hsw = 4'h1;
    hdir = 4'hF;
    coded = '0;
    mtype = '0;
    maxd = 32'h00001000;
    refc[W +: W] = 32'h00000BB8;
    refc[0 +: W] = 32'h00001388;
    jog = 1'h1;
    note(1, 1'h1);
    note(0, 1'h1);
    go(4'h3);
    conclude();
  end
endmodule // tb_axis_home_search_sequencer
